// ---- rtl/sfw_pkg.sv ----
// sfw_pkg: constants and types shared by the software fault watchdog
// assumes a single 50 MHz clock domain and an apb register slave
package sfw_pkg;
  // register map
  localparam logic [15:0] SFW_CTRL_ADDR = 16'h0024;
  localparam logic [7:0] SFW_CTRL_RESET = 8'h7f;
  localparam int SFW_ACTIVE_BIT = 7;
  localparam int SFW_TOP_BIT = 6;
  localparam int SFW_COUNT_W = 7;
  // prescale: machine cycles per countdown step
  localparam int SFW_STEP_CYCLES = 12288;
  // reset pulse on the pin
  localparam int SFW_CLK_NS = 20;
  localparam int SFW_PULSE_NS = 500;
  localparam int SFW_PULSE_CYCLES = (SFW_PULSE_NS + SFW_CLK_NS - 1) / SFW_CLK_NS;
  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } sfw_apb_req_type;
  // pulse generator states
  typedef enum logic [0:0] {
    SFW_IDLE = 1'b0,
    SFW_PULSE = 1'b1
  } sfw_state_type;
endpackage : sfw_pkg

// ---- rtl/sfw_pulse.sv ----
// sfw_pulse: stretches a one-cycle trigger into a fixed low reset pulse
// assumes trigger is synchronous to clk_in
`timescale 1ns/1ps
module sfw_pulse #(
  parameter int PULSE_CYCLES = sfw_pkg::SFW_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // trigger and pulse
  input wire logic trigger_in,
  output logic nreset_pin_out
);
  import sfw_pkg::*;
  localparam int CW = $clog2(PULSE_CYCLES + 1);
  initial begin
    if (PULSE_CYCLES < 1) $error("pulse length must be at least one cycle");
  end
  sfw_state_type state;
  logic [CW-1:0] remaining;
  wire logic last_cycle = (remaining == CW'(1));
  // hold the pin low for the pulse length, then release
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= SFW_IDLE;
      remaining <= '0;
      nreset_pin_out <= 1'b1;
    end else begin
      unique case (state)
        SFW_IDLE: begin
          if (trigger_in) begin
            state <= SFW_PULSE;
            remaining <= CW'(PULSE_CYCLES);
            nreset_pin_out <= 1'b0;
          end
        end
        SFW_PULSE: begin
          remaining <= remaining - CW'(1);
          if (last_cycle) begin
            state <= SFW_IDLE;
            nreset_pin_out <= 1'b1;
          end
        end
      endcase
    end
  end
  a_pulse_low_len: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == SFW_IDLE && trigger_in) |=> !nreset_pin_out [*2])
    else $error("reset pulse shorter than two cycles");
endmodule : sfw_pulse

// ---- rtl/sfw_watchdog.sv ----
// sfw_watchdog: countdown watchdog with one apb control register
// assumes apb master on clk_in; system reset also clears this block
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module sfw_watchdog #(
  parameter int STEP_CYCLES = sfw_pkg::SFW_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire sfw_pkg::sfw_apb_req_type apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // cpu status
  input wire logic halt_exec_in,
  input wire logic wait_mode_in,
  // reset pin drive and activation status
  output logic nreset_pin_out,
  output logic watchdog_active_out
);
  import sfw_pkg::*;
  localparam int PW = $clog2(STEP_CYCLES);
  initial begin
    if (STEP_CYCLES < 3) $error("step length must be at least three cycles");
  end

  logic watchdog_active;
  logic [SFW_COUNT_W-1:0] count;
  logic [PW-1:0] prescale;
  logic fire;

  // bus decode
  wire logic access = apb_in.psel && apb_in.penable;
  wire logic hit = (apb_in.paddr == SFW_CTRL_ADDR);
  wire logic ctrl_wr = access && apb_in.pwrite && hit;
  wire logic ctrl_rd = access && !apb_in.pwrite && hit;
  wire logic [7:0] wdata = apb_in.pwdata[7:0];
  wire logic [7:0] ctrl_value = {watchdog_active, count};

  // step enable: one pulse every step period (wait mode does not stop it)
  wire logic step = (prescale == PW'(STEP_CYCLES - 1));
  wire logic [SFW_COUNT_W-1:0] next_count = count - SFW_COUNT_W'(1);
  wire logic rollover = step && (count == {1'b1, 6'h00});
  // software reset: activation set with top bit clear
  wire logic soft_reset = ctrl_wr && wdata[SFW_ACTIVE_BIT] && !wdata[SFW_TOP_BIT];
  wire logic halt_reset = watchdog_active && halt_exec_in;
  wire logic next_fire = (watchdog_active && rollover) || soft_reset || halt_reset;

  // apb answer terms: ready in the access cycle, error for any other address
  wire logic setup = apb_in.psel && !apb_in.penable;
  wire logic next_pready = setup;
  wire logic next_pslverr = setup && !hit;
  // read data is the live register, so a read never waits for the counter
  wire logic [31:0] next_prdata = (apb_in.psel && hit) ? {24'h00_0000, ctrl_value} : 32'h0000_0000;

  // prescaler restarts on every refresh so each step is a full period
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prescale <= '0;
    end else if (ctrl_wr || step) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + PW'(1);
    end
  end

  // control register: write loads count, step decrements it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      watchdog_active <= SFW_CTRL_RESET[SFW_ACTIVE_BIT];
      count <= SFW_CTRL_RESET[SFW_COUNT_W-1:0];
    end else if (ctrl_wr) begin
      watchdog_active <= watchdog_active | wdata[SFW_ACTIVE_BIT];
      count <= wdata[SFW_COUNT_W-1:0];
    end else if (step) begin
      count <= next_count;
    end
  end

  // one-cycle trigger to the pulse generator
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fire <= 1'b0;
    end else begin
      fire <= next_fire;
    end
  end

  // apb answer: zero wait states, unmapped reads zero with error
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      watchdog_active_out <= 1'b0;
    end else begin
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      prdata_out <= next_prdata;
      watchdog_active_out <= watchdog_active;
    end
  end

  sfw_pulse #(.PULSE_CYCLES(SFW_PULSE_CYCLES)) u_pulse (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .trigger_in(fire),
    .nreset_pin_out(nreset_pin_out)
  );

  // checks
  sequence s_rollover;
    watchdog_active && step && count == 7'h40;
  endsequence
  a_rollover_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_rollover |-> ##2 !nreset_pin_out)
    else $error("rollover did not pull the reset pin");
  a_active_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
    watchdog_active |=> watchdog_active)
    else $error("activation bit cleared without reset");
  a_step_period: assert property (@(posedge clk_in) disable iff (!nrst_in)
    step |=> !step [*2])
    else $error("step enable repeated too soon");
  a_count_step: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (step && !ctrl_wr) |=> count == $past(count) - 7'h01)
    else $error("count did not decrement on step");
  a_soft_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
    soft_reset |-> ##2 !nreset_pin_out)
    else $error("software reset ignored");
  a_halt_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
    halt_reset |-> ##2 !nreset_pin_out)
    else $error("halt while active did not reset");
  a_read_live: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (apb_in.psel && !apb_in.penable && hit && !apb_in.pwrite)
    |=> prdata_out[7:0] == $past(ctrl_value))
    else $error("read did not show live value");
  a_read_no_effect: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (ctrl_rd && !step) |=> count == $past(count))
    else $error("read disturbed the count");
  a_no_fire_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!watchdog_active && !ctrl_wr) |=> !fire)
    else $error("inactive watchdog fired");

  // checker helper: cycles since the last step or refresh, apart from the prescaler
  logic [PW:0] since_step;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      since_step <= '0;
    end else if (ctrl_wr || step) begin
      since_step <= '0;
    end else begin
      since_step <= since_step + (PW+1)'(1);
    end
  end

  // named steps of the bus and reset behaviour
  sequence s_refresh_write;
    ctrl_wr && wdata[SFW_ACTIVE_BIT];
  endsequence
  sequence s_setup_mapped;
    apb_in.psel && !apb_in.penable && hit;
  endsequence
  sequence s_setup_unmapped;
    apb_in.psel && !apb_in.penable && !hit;
  endsequence
  sequence s_quiet_cycle;
    !ctrl_wr && !step;
  endsequence
  sequence s_step_no_roll;
    watchdog_active && step && count != 7'h40 && !soft_reset && !halt_reset;
  endsequence

  // a step comes exactly one full period after the last step or refresh
  a_step_exact: assert property (@(posedge clk_in) disable iff (!nrst_in)
    step |-> since_step == (PW+1)'(STEP_CYCLES - 1))
    else $error("step period not exact");
  // the period never overruns
  a_step_bound: assert property (@(posedge clk_in) disable iff (!nrst_in)
    since_step < (PW+1)'(STEP_CYCLES))
    else $error("step period overran");
  // a write loads the seven counter bits
  a_write_loads: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ctrl_wr |=> count == $past(wdata[SFW_COUNT_W-1:0]))
    else $error("write did not load the count");
  // a write with the activation bit set arms the watchdog
  a_write_arms: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_refresh_write |=> watchdog_active)
    else $error("activation bit not set by write");
  // nothing but a write sets the activation bit
  a_inactive_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!watchdog_active && !(ctrl_wr && wdata[SFW_ACTIVE_BIT])) |=> !watchdog_active)
    else $error("activation bit set without software");
  // every refresh restarts the prescaler
  a_prescale_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ctrl_wr |=> prescale == '0)
    else $error("refresh did not restart prescaler");
  // the prescaler counts up between steps
  a_prescale_count: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_quiet_cycle |=> prescale == $past(prescale) + PW'(1))
    else $error("prescaler did not advance");
  // the step reloads the prescaler
  a_step_reload: assert property (@(posedge clk_in) disable iff (!nrst_in)
    step |=> prescale == '0)
    else $error("step did not reload prescaler");
  // wait mode leaves counting untouched
  a_wait_no_effect: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wait_mode_in && !ctrl_wr && !step) |=> prescale == $past(prescale) + PW'(1))
    else $error("wait mode disturbed the prescaler");
  // the count holds between steps
  a_count_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_quiet_cycle |=> count == $past(count))
    else $error("count moved without a step");
  // rollover with the watchdog armed triggers the pulse next cycle
  a_rollover_fire: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_rollover |=> fire)
    else $error("rollover did not trigger");
  // a step away from 40h triggers nothing
  a_no_roll_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_step_no_roll |=> !fire)
    else $error("step fired without rollover");
  // software reset triggers the pulse next cycle
  a_soft_fire: assert property (@(posedge clk_in) disable iff (!nrst_in)
    soft_reset |=> fire)
    else $error("software reset did not trigger");
  // halt while armed triggers the pulse next cycle
  a_halt_fire: assert property (@(posedge clk_in) disable iff (!nrst_in)
    halt_reset |=> fire)
    else $error("halt did not trigger");
  // the pin only falls after a trigger
  a_pin_from_fire: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(nreset_pin_out) |-> $past(fire))
    else $error("reset pin fell without a trigger");
  // unmapped writes leave the register alone
  a_unmapped_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (access && apb_in.pwrite && !hit && !step)
    |=> count == $past(count) && watchdog_active == $past(watchdog_active))
    else $error("unmapped write changed the register");
  // ready follows every setup cycle
  a_pready_access: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (apb_in.psel && !apb_in.penable) |=> pready_out)
    else $error("no ready in access cycle");
  // ready stays low outside access cycles
  a_pready_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(apb_in.psel && !apb_in.penable) |=> !pready_out)
    else $error("ready outside access cycle");
  // an unmapped address answers with an error
  a_slverr_unmapped: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_setup_unmapped |=> pslverr_out && pready_out)
    else $error("unmapped access without error");
  // the control register answers without error
  a_slverr_mapped: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_setup_mapped |=> !pslverr_out)
    else $error("mapped access flagged an error");
  // unmapped reads return zero
  a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (apb_in.psel && !hit) |=> prdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  // the status output mirrors the activation bit
  a_active_mirror: assert property (@(posedge clk_in) disable iff (!nrst_in)
    1'b1 |=> watchdog_active_out == $past(watchdog_active))
    else $error("activation output out of step");
endmodule : sfw_watchdog

// ---- bench/tb.sv ----
// tb: self-checking bench for the software fault watchdog
// assumes sfw_pkg and sfw_watchdog are compiled first; apb master driven here
`timescale 1ns/1ps
module tb;
  import sfw_pkg::*;
  localparam int STEP = 8;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic halt_exec_in = 1'b0;
  logic wait_mode_in = 1'b0;
  sfw_apb_req_type apb_in = '0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, nreset_pin_out, watchdog_active_out;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int checks = 0;
  int n;

  // device under test, short prescale for simulation
  sfw_watchdog #(.STEP_CYCLES(STEP)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .apb_in(apb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .halt_exec_in(halt_exec_in),
    .wait_mode_in(wait_mode_in), .nreset_pin_out(nreset_pin_out),
    .watchdog_active_out(watchdog_active_out));

  // 50 MHz clock
  always #10 clk_in = ~clk_in;

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int k = 0;
    @(posedge clk_in);
    apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h00_0000, d}};
    @(posedge clk_in);
    apb_in.penable <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 50);
    if (pready_out !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t no ready from the slave", $time);
    end
    rd = prdata_out;
    err = pslverr_out;
    apb_in <= '0;
  endtask : apb

  // count edges until the reset pin is low, bounded
  task automatic wait_low(input int lim);
    n = 0;
    while (nreset_pin_out !== 1'b0 && n < lim) begin
      @(posedge clk_in);
      n++;
    end
  endtask : wait_low

  // measure the low pulse and let the pin recover
  task automatic pulse_len();
    n = 0;
    while (nreset_pin_out === 1'b0 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    check(n, SFW_PULSE_CYCLES);
  endtask : pulse_len

  // closing report and verdict
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // reset value, unmapped access, halt while inactive
  task automatic t_reset_and_map();
    apb(1'b0, SFW_CTRL_ADDR, 8'h00);
    check(rd, 32'h0000_007f);
    apb(1'b0, 16'h0028, 8'h00);
    check(rd, 32'h0000_0000);
    check(err, 1'b1);
    halt_exec_in <= 1'b1;
    @(posedge clk_in);
    halt_exec_in <= 1'b0;
    wait_low(6);
    check(nreset_pin_out, 1'b1);
  endtask : t_reset_and_map

  // refresh with one increment, countdown rolls into a reset
  task automatic t_timeout();
    wait_mode_in <= 1'b1;
    apb(1'b1, SFW_CTRL_ADDR, 8'hc1);
    apb(1'b0, SFW_CTRL_ADDR, 8'h00);
    check(rd, 32'h0000_00c1);
    wait_low(4 * STEP);
    check(n >= STEP && n <= 2 * STEP, 1'b1);
    check(watchdog_active_out, 1'b1);
    pulse_len();
    wait_mode_in <= 1'b0;
  endtask : t_timeout

  // activation sticks, halt and software reset fire at once
  task automatic t_sticky_halt_soft();
    apb(1'b1, SFW_CTRL_ADDR, 8'h7f);
    apb(1'b0, SFW_CTRL_ADDR, 8'h00);
    check(rd, 32'h0000_00ff);
    halt_exec_in <= 1'b1;
    @(posedge clk_in);
    halt_exec_in <= 1'b0;
    wait_low(4);
    check(nreset_pin_out, 1'b0);
    pulse_len();
    apb(1'b1, SFW_CTRL_ADDR, 8'hbf);
    wait_low(4);
    check(nreset_pin_out, 1'b0);
    pulse_len();
  endtask : t_sticky_halt_soft

  // regular refresh keeps the pin high across several step periods
  task automatic t_refresh();
    repeat (4) begin
      apb(1'b1, SFW_CTRL_ADDR, 8'hc1);
      wait_low(10);
      check(nreset_pin_out, 1'b1);
    end
  endtask : t_refresh

  // reset in mid-run clears the activation bit and restores the count
  task automatic t_mid_reset();
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check(watchdog_active_out, 1'b0);
    check(pready_out, 1'b0);
    check(nreset_pin_out, 1'b1);
    nrst_in <= 1'b1;
    apb(1'b0, SFW_CTRL_ADDR, 8'h00);
    check(rd, 32'h0000_007f);
    halt_exec_in <= 1'b1;
    @(posedge clk_in);
    halt_exec_in <= 1'b0;
    wait_low(6);
    check(nreset_pin_out, 1'b1);
  endtask : t_mid_reset

  // main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset_and_map();
    t_refresh();
    t_timeout();
    t_sticky_halt_soft();
    t_mid_reset();
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    #(20 * 3000);
    miscompares++;
    tally_and_finish();
  end
endmodule : tb
